// >>> logic/riwc_defs.vh
// constants for the reset, interrupt and wait controller
`ifndef RIWC_DEFS_VH
`define RIWC_DEFS_VH
// register offsets on the plain register port
`define RIWC_ADDR_MISC 8'h09
`define RIWC_ADDR_STAT 8'h0A
// misc control register layout and reset value
`define RIWC_MISC_RST 8'h10
`define RIWC_MISC_EN_A 0
`define RIWC_MISC_EN_B 1
`define RIWC_MISC_LAT_A 2
`define RIWC_MISC_LAT_B 3
`define RIWC_MISC_FAST 4
`define RIWC_MISC_HSDIV 5
`define RIWC_MISC_FLY 6
`define RIWC_MISC_VSEL 7
// condition code mask bit position
`define RIWC_CC_I 3
// stack pointer: fixed page, low byte reset value
`define RIWC_SP_PAGE 8'h01
`define RIWC_SP_LO_RST 8'hFF
// vectors, high byte at the even address
`define RIWC_VEC_RESET 16'hFFFE
`define RIWC_VEC_TRAP 16'hFFFC
`define RIWC_VEC_USB_ESUSP 16'hFFFA
`define RIWC_VEC_DDC_CI 16'hFFF8
`define RIWC_VEC_DDC 16'hFFF6
`define RIWC_VEC_EDGE_B 16'hFFF4
`define RIWC_VEC_EDGE_A 16'hFFF2
`define RIWC_VEC_TMR_IC 16'hFFF0
`define RIWC_VEC_TMR_OC 16'hFFEE
`define RIWC_VEC_TMR_OVF 16'hFFEC
`define RIWC_VEC_I2C 16'hFFEA
`define RIWC_VEC_USB 16'hFFE6
// timer counter value after reset
`define RIWC_TMR_CNT_RST 16'hFFFC
// oscillator start delay in cpu clock cycles
`define RIWC_OSC_DELAY 13'h1000
// forbidden fetch window (protects low-page registers)
`define RIWC_ILL_LO 16'h0000
`define RIWC_ILL_HI 16'h00FF
// index of the last context byte pushed per interrupt (five bytes, steps 0..4)
`define RIWC_CTX_LAST 3'h4
`endif

// >>> logic/riwc_ctrl.v
// reset, interrupt and wait controller for an 8-bit cpu core
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "riwc_defs.vh"

// How it works
// - opcode fetch from the forbidden address window raises a reset.
// - an opcode matching no valid instruction raises a reset.
// - any reset fetches the restart vector from the two top addresses.
// - reset sets the stack pointer to the top of the stack.
// - reset sets the mask bit and clears the wait latch.
// - reset holds the core a fixed cycle count after the oscillator restarts.
// - reset clears timer prescaler, loads counter, clears enables, stops clock.
// - reset sets the fast clock select bit, meaning 24 MHz external clock.
// - reset clears port directions, port data, watchdog and peripheral registers.
// - interrupt entry pushes pc, x, a and cc, then sets the mask.
// - after the push, pc loads from the serviced source's vector pair.
// - return restores registers; mask cleared only if stacked mask was zero.
// - fixed priority: reset, trap, then descending vector address.
// - trap is always taken; with mask set it is the only one.
// - masked or disabled requests stay pending until enabled and unmasked.
// - falling edge sets the input latch; request needs enable and clear mask.
// - interrupts start only at the next instruction boundary, or at once from wait.
// - peripheral flag clear sequence also drops its pending request.
// - wait halts the cpu while clock and peripherals keep running.
// - entering wait clears the mask; interrupt or reset ends wait.
// - interrupt uses five stack bytes, pc low first; call uses two.
// - edge latches sit in misc control, set by hardware, cleared by software.
module riwc_ctrl #(
    parameter [12:0] OSC_DELAY_CYC = `RIWC_OSC_DELAY,
    parameter [15:0] ILL_ADDR_LO = `RIWC_ILL_LO,
    parameter [15:0] ILL_ADDR_HI = `RIWC_ILL_HI
) (
    input wire CLK,
    input wire RSTN,
    input wire RESET_PIN_N,
    input wire EXT_EDGE_IRQ_A,
    input wire EXT_EDGE_IRQ_B,
    input wire FETCH_STROBE,
    input wire [15:0] FETCH_ADDR,
    input wire OPCODE_ILLEGAL,
    input wire CORE_BOUNDARY,
    input wire CORE_TRAP,
    input wire CORE_INTERRUPT_RETURN_INSTR,
    input wire CORE_WFI,
    input wire CORE_SEI,
    input wire CORE_CLI,
    input wire [15:0] CORE_PC,
    input wire [7:0] CORE_X,
    input wire [7:0] CORE_A,
    input wire [7:0] CORE_CC,
    input wire CORE_SP_LOAD,
    input wire [7:0] CORE_SP_DATA,
    input wire [7:0] PERIPH_IRQ,
    output reg [15:0] MEM_ADDR,
    output reg [7:0] MEM_WDATA,
    output reg MEM_WR,
    output reg MEM_RD,
    input wire [7:0] MEM_RDATA,
    output wire CORE_RST,
    output wire CORE_HOLD,
    output reg PC_LOAD,
    output reg [15:0] PC_VALUE,
    output reg CTX_LOAD,
    output reg [7:0] CC_VALUE,
    output reg [7:0] A_VALUE,
    output reg [7:0] X_VALUE,
    output wire [15:0] SP_VALUE,
    output reg I_MASK,
    output wire WAIT_MODE,
    output wire OSC_EN,
    output wire PERIPH_RST,
    output wire [15:0] TIMER_CNT_INIT,
    output wire FAST_CLK_SEL,
    output wire VSYNC_SEL,
    output wire FLY_SYN_SEL,
    output wire HSYNC_DIV_EN,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA
);

    localparam ST_RST = 3'h0;
    localparam ST_VEC = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_PUSH = 3'h4;
    localparam ST_POP = 3'h5;
    localparam [12:0] OSC_LAST = OSC_DELAY_CYC - 13'h0001;

    reg [2:0] state;
    reg [12:0] cnt;
    reg [7:0] sp_lo;
    reg [15:0] vec;
    reg [15:0] ctx_pc;
    reg [7:0] ctx_x;
    reg [7:0] ctx_a;
    reg [7:0] ctx_cc;
    reg [7:0] push_byte;
    reg [7:0] misc_control_reg;
    reg pin_meta;
    reg pin_sync;
    reg a_meta;
    reg a_sync;
    reg a_prev;
    reg b_meta;
    reg b_sync;
    reg b_prev;
    reg irq_any;
    reg [3:0] irq_idx;
    reg [15:0] irq_vec;
    integer k;

    wire ill_fetch;
    wire rst_src;
    wire fall_a;
    wire fall_b;
    wire [9:0] req;

    // reset pin and edge inputs through two flops each
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            a_meta <= 1'b1;
            a_sync <= 1'b1;
            a_prev <= 1'b1;
            b_meta <= 1'b1;
            b_sync <= 1'b1;
            b_prev <= 1'b1;
        end else begin
            pin_meta <= RESET_PIN_N;
            pin_sync <= pin_meta;
            a_meta <= EXT_EDGE_IRQ_A;
            a_sync <= a_meta;
            a_prev <= a_sync;
            b_meta <= EXT_EDGE_IRQ_B;
            b_sync <= b_meta;
            b_prev <= b_sync;
        end
    end

    // reset sources merged; pin is held low long enough by the board
    assign ill_fetch = FETCH_STROBE && (FETCH_ADDR >= ILL_ADDR_LO) && (FETCH_ADDR <= ILL_ADDR_HI);
    assign rst_src = ~pin_sync | ill_fetch | OPCODE_ILLEGAL;
    assign fall_a = a_prev & ~a_sync;
    assign fall_b = b_prev & ~b_sync;

    // misc control register with edge latches
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            misc_control_reg <= `RIWC_MISC_RST;
        end else if (rst_src || state == ST_RST) begin
            misc_control_reg <= `RIWC_MISC_RST; // same edge as core reset, no stale bits
        end else begin
            if (REG_WR && REG_ADDR == `RIWC_ADDR_MISC) begin
                misc_control_reg[`RIWC_MISC_VSEL] <= REG_WDATA[`RIWC_MISC_VSEL];
                misc_control_reg[`RIWC_MISC_FLY] <= REG_WDATA[`RIWC_MISC_FLY];
                misc_control_reg[`RIWC_MISC_HSDIV] <= REG_WDATA[`RIWC_MISC_HSDIV];
                misc_control_reg[`RIWC_MISC_FAST] <= REG_WDATA[`RIWC_MISC_FAST];
                misc_control_reg[`RIWC_MISC_EN_B] <= REG_WDATA[`RIWC_MISC_EN_B];
                misc_control_reg[`RIWC_MISC_EN_A] <= REG_WDATA[`RIWC_MISC_EN_A];
            end
            // writing zero clears a latch, a falling edge in the same cycle wins
            misc_control_reg[`RIWC_MISC_LAT_A] <= fall_a | (misc_control_reg[`RIWC_MISC_LAT_A] &
                ~(REG_WR && REG_ADDR == `RIWC_ADDR_MISC && !REG_WDATA[`RIWC_MISC_LAT_A]));
            misc_control_reg[`RIWC_MISC_LAT_B] <= fall_b | (misc_control_reg[`RIWC_MISC_LAT_B] &
                ~(REG_WR && REG_ADDR == `RIWC_ADDR_MISC && !REG_WDATA[`RIWC_MISC_LAT_B]));
        end
    end

    // requests by priority slot, slot 0 highest; peripheral flags hold their own latch
    assign req = {PERIPH_IRQ[7:3],
        misc_control_reg[`RIWC_MISC_LAT_A] & misc_control_reg[`RIWC_MISC_EN_A],
        misc_control_reg[`RIWC_MISC_LAT_B] & misc_control_reg[`RIWC_MISC_EN_B],
        PERIPH_IRQ[2:0]};

    // lowest slot number wins
    always @* begin
        irq_any = 1'b0;
        irq_idx = 4'h0;
        for (k = 9; k >= 0; k = k - 1) begin
            if (req[k]) begin
                irq_any = 1'b1;
                irq_idx = k[3:0];
            end
        end
    end

    // vector of the winning slot
    always @* begin
        case (irq_idx)
            4'h0: irq_vec = `RIWC_VEC_USB_ESUSP;
            4'h1: irq_vec = `RIWC_VEC_DDC_CI;
            4'h2: irq_vec = `RIWC_VEC_DDC;
            4'h3: irq_vec = `RIWC_VEC_EDGE_B;
            4'h4: irq_vec = `RIWC_VEC_EDGE_A;
            4'h5: irq_vec = `RIWC_VEC_TMR_IC;
            4'h6: irq_vec = `RIWC_VEC_TMR_OC;
            4'h7: irq_vec = `RIWC_VEC_TMR_OVF;
            4'h8: irq_vec = `RIWC_VEC_I2C;
            default: irq_vec = `RIWC_VEC_USB;
        endcase
    end

    // context byte for push step, pc low first
    always @* begin
        case (cnt[2:0])
            3'h0: push_byte = ctx_pc[7:0];
            3'h1: push_byte = ctx_pc[15:8];
            3'h2: push_byte = ctx_x;
            3'h3: push_byte = ctx_a;
            default: push_byte = ctx_cc;
        endcase
    end

    // sequencer: reset delay, vector fetch, run, wait, push, pop
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_RST;
            cnt <= 13'h0000;
            sp_lo <= `RIWC_SP_LO_RST;
            I_MASK <= 1'b1;
            vec <= `RIWC_VEC_RESET;
            ctx_pc <= 16'h0000;
            ctx_x <= 8'h00;
            ctx_a <= 8'h00;
            ctx_cc <= 8'h00;
            MEM_ADDR <= 16'h0000;
            MEM_WDATA <= 8'h00;
            MEM_WR <= 1'b0;
            MEM_RD <= 1'b0;
            PC_LOAD <= 1'b0;
            PC_VALUE <= 16'h0000;
            CTX_LOAD <= 1'b0;
            CC_VALUE <= 8'h00;
            A_VALUE <= 8'h00;
            X_VALUE <= 8'h00;
        end else begin
            MEM_WR <= 1'b0;
            MEM_RD <= 1'b0;
            PC_LOAD <= 1'b0;
            CTX_LOAD <= 1'b0;
            if (rst_src) begin
                state <= ST_RST;
                cnt <= 13'h0000;
                sp_lo <= `RIWC_SP_LO_RST;
                I_MASK <= 1'b1;
                vec <= `RIWC_VEC_RESET;
            end else begin
                case (state)
                    ST_RST: begin
                        if (cnt == OSC_LAST) begin
                            state <= ST_VEC;
                            cnt <= 13'h0000;
                        end else begin
                            cnt <= cnt + 13'h0001;
                        end
                    end
                    ST_VEC: begin
                        cnt <= cnt + 13'h0001;
                        case (cnt[1:0])
                            2'h0: begin
                                MEM_RD <= 1'b1;
                                MEM_ADDR <= vec;
                            end
                            2'h1: begin
                                MEM_RD <= 1'b1;
                                MEM_ADDR <= vec + 16'h0001;
                            end
                            2'h2: PC_VALUE[15:8] <= MEM_RDATA;
                            default: begin
                                PC_VALUE[7:0] <= MEM_RDATA;
                                PC_LOAD <= 1'b1;
                                state <= ST_RUN;
                                cnt <= 13'h0000;
                            end
                        endcase
                    end
                    ST_RUN: begin
                        if (CORE_SP_LOAD) begin
                            sp_lo <= CORE_SP_DATA; // core's own calls use two bytes
                        end
                        if (CORE_SEI) begin
                            I_MASK <= 1'b1;
                        end else if (CORE_CLI) begin
                            I_MASK <= 1'b0;
                        end
                        // decisions only at an instruction boundary
                        if (CORE_BOUNDARY) begin
                            ctx_pc <= CORE_PC;
                            ctx_x <= CORE_X;
                            ctx_a <= CORE_A;
                            ctx_cc <= CORE_CC;
                            ctx_cc[`RIWC_CC_I] <= I_MASK;
                            cnt <= 13'h0000;
                            if (CORE_TRAP) begin
                                vec <= `RIWC_VEC_TRAP;
                                state <= ST_PUSH;
                            end else if (CORE_INTERRUPT_RETURN_INSTR) begin
                                state <= ST_POP;
                            end else if (CORE_WFI) begin
                                I_MASK <= 1'b0;
                                state <= ST_WAIT;
                            end else if (irq_any && !I_MASK) begin
                                vec <= irq_vec;
                                state <= ST_PUSH;
                            end
                        end
                    end
                    ST_WAIT: begin
                        // core held, clock and peripherals keep running
                        if (irq_any && !I_MASK) begin
                            ctx_pc <= CORE_PC;
                            ctx_x <= CORE_X;
                            ctx_a <= CORE_A;
                            ctx_cc <= CORE_CC;
                            ctx_cc[`RIWC_CC_I] <= I_MASK;
                            vec <= irq_vec;
                            cnt <= 13'h0000;
                            state <= ST_PUSH;
                        end
                    end
                    ST_PUSH: begin
                        MEM_WR <= 1'b1;
                        MEM_ADDR <= {`RIWC_SP_PAGE, sp_lo};
                        MEM_WDATA <= push_byte;
                        sp_lo <= sp_lo - 8'h01;
                        if (cnt[2:0] == `RIWC_CTX_LAST) begin
                            I_MASK <= 1'b1;
                            cnt <= 13'h0000;
                            state <= ST_VEC;
                        end else begin
                            cnt <= cnt + 13'h0001;
                        end
                    end
                    ST_POP: begin
                        // reads issue for steps 0..4, data captured two steps later
                        cnt <= cnt + 13'h0001;
                        if (cnt[2:0] <= `RIWC_CTX_LAST) begin
                            MEM_RD <= 1'b1;
                            MEM_ADDR <= {`RIWC_SP_PAGE, sp_lo + 8'h01};
                            sp_lo <= sp_lo + 8'h01;
                        end
                        case (cnt[2:0])
                            3'h2: begin
                                CC_VALUE <= MEM_RDATA;
                                I_MASK <= MEM_RDATA[`RIWC_CC_I];
                            end
                            3'h3: A_VALUE <= MEM_RDATA;
                            3'h4: X_VALUE <= MEM_RDATA;
                            3'h5: PC_VALUE[15:8] <= MEM_RDATA;
                            3'h6: begin
                                PC_VALUE[7:0] <= MEM_RDATA;
                                PC_LOAD <= 1'b1;
                                CTX_LOAD <= 1'b1;
                                cnt <= 13'h0000;
                                state <= ST_RUN;
                            end
                            default: ;
                        endcase
                    end
                    default: state <= ST_RST;
                endcase
            end
        end
    end

    // register read data, valid only the cycle after the strobe
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD && REG_ADDR == `RIWC_ADDR_MISC) begin
            REG_RDATA <= misc_control_reg;
        end else if (REG_RD && REG_ADDR == `RIWC_ADDR_STAT) begin
            REG_RDATA <= {5'h00, state == ST_RST, I_MASK, state == ST_WAIT};
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // core and peripheral controls
    assign CORE_RST = (state == ST_RST);
    assign CORE_HOLD = (state != ST_RUN);
    assign WAIT_MODE = (state == ST_WAIT);
    assign OSC_EN = ~rst_src;
    assign PERIPH_RST = (state == ST_RST);
    assign TIMER_CNT_INIT = `RIWC_TMR_CNT_RST;
    assign SP_VALUE = {`RIWC_SP_PAGE, sp_lo};
    assign FAST_CLK_SEL = misc_control_reg[`RIWC_MISC_FAST];
    assign VSYNC_SEL = misc_control_reg[`RIWC_MISC_VSEL];
    assign FLY_SYN_SEL = misc_control_reg[`RIWC_MISC_FLY];
    assign HSYNC_DIV_EN = misc_control_reg[`RIWC_MISC_HSDIV];

endmodule // riwc_ctrl

// >>> sim/riwc_mem_model.sv
// memory partner: stack page storage and vector read answers
`timescale 1ns/1ps
module riwc_mem_model (
    input wire CLK,
    input wire [15:0] MEM_ADDR,
    input wire [7:0] MEM_WDATA,
    input wire MEM_WR,
    input wire MEM_RD,
    output logic [7:0] MEM_RDATA
);
    logic [7:0] stk [0:255];
    initial MEM_RDATA = 8'h00;
    // stack page writes kept, other reads answer with the address low byte
    always @(posedge CLK) begin
        if (MEM_WR && MEM_ADDR[15:8] == 8'h01) stk[MEM_ADDR[7:0]] <= MEM_WDATA;
        // data stand one cycle only, then an inverted value
        if (MEM_RD) MEM_RDATA <= (MEM_ADDR[15:8] == 8'h01) ? stk[MEM_ADDR[7:0]] : MEM_ADDR[7:0];
        else MEM_RDATA <= ~MEM_RDATA;
    end
endmodule // riwc_mem_model

// >>> sim/riwc_ctrl_checker.sv
// port-level assertions for the reset, interrupt and wait controller
`timescale 1ns/1ps
`include "riwc_defs.vh"
module riwc_ctrl_checker #(
    parameter [15:0] ILL_ADDR_HI = `RIWC_ILL_HI
) (
    input wire CLK, RSTN, FETCH_STROBE, OPCODE_ILLEGAL, MEM_WR, MEM_RD,
    input wire CORE_RST, CORE_HOLD, I_MASK, WAIT_MODE, PERIPH_RST, FAST_CLK_SEL, PC_LOAD,
    input wire [15:0] FETCH_ADDR, MEM_ADDR, SP_VALUE, TIMER_CNT_INIT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // reset and vector relations
    property p_vec_rd; MEM_RD && MEM_ADDR == `RIWC_VEC_RESET |=> MEM_RD && MEM_ADDR == 16'hFFFF; endproperty
    a_vec_rd: assert property (p_vec_rd) else $error("reset vector low byte not read next");
    property p_sp_top; CORE_RST |-> SP_VALUE == 16'h01FF; endproperty
    a_sp_top: assert property (p_sp_top) else $error("stack pointer not at top in reset");
    property p_mask_rst; CORE_RST |-> I_MASK && !WAIT_MODE; endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask or wait wrong in reset");
    property p_fast; CORE_RST |-> FAST_CLK_SEL && TIMER_CNT_INIT == `RIWC_TMR_CNT_RST; endproperty
    a_fast: assert property (p_fast) else $error("fast select or timer init wrong in reset");
    property p_periph; PERIPH_RST == CORE_RST; endproperty
    a_periph: assert property (p_periph) else $error("peripheral reset differs from core reset");
    property p_ill_fetch; FETCH_STROBE && FETCH_ADDR <= ILL_ADDR_HI |-> ##[0:4] CORE_RST; endproperty
    a_ill_fetch: assert property (p_ill_fetch) else $error("illegal fetch gave no reset");
    property p_ill_op; OPCODE_ILLEGAL |-> ##[0:4] CORE_RST; endproperty
    a_ill_op: assert property (p_ill_op) else $error("illegal opcode gave no reset");
    // context push shape and wait mode
    property p_push; $rose(MEM_WR) |-> MEM_WR [*5] ##1 !MEM_WR; endproperty
    a_push: assert property (p_push) else $error("push is not five bytes");
    property p_mask_push; $fell(MEM_WR) |-> I_MASK; endproperty
    a_mask_push: assert property (p_mask_push) else $error("mask not set after push");
    property p_wait; WAIT_MODE |-> !I_MASK && CORE_HOLD; endproperty
    a_wait: assert property (p_wait) else $error("wait with mask set or core running");
    c_push: cover property ($rose(MEM_WR));
    c_wait: cover property ($rose(WAIT_MODE));
    c_load: cover property (PC_LOAD && !CORE_RST);
endmodule // riwc_ctrl_checker
bind riwc_ctrl riwc_ctrl_checker #(.ILL_ADDR_HI(ILL_ADDR_HI)) chk_u (.CLK(CLK), .RSTN(RSTN),
    .FETCH_STROBE(FETCH_STROBE), .OPCODE_ILLEGAL(OPCODE_ILLEGAL), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
    .CORE_RST(CORE_RST), .CORE_HOLD(CORE_HOLD), .I_MASK(I_MASK), .WAIT_MODE(WAIT_MODE),
    .PERIPH_RST(PERIPH_RST), .FAST_CLK_SEL(FAST_CLK_SEL), .PC_LOAD(PC_LOAD), .FETCH_ADDR(FETCH_ADDR),
    .MEM_ADDR(MEM_ADDR), .SP_VALUE(SP_VALUE), .TIMER_CNT_INIT(TIMER_CNT_INIT));

// >>> sim/riwc_ctrl_tb_top.sv
// self-checking testbench for the reset, interrupt and wait controller
`timescale 1ns/1ps
`include "riwc_defs.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module riwc_ctrl_tb_top;
    logic CLK = 0, RSTN = 0, RESET_PIN_N = 1, EXT_EDGE_IRQ_A = 1, EXT_EDGE_IRQ_B = 1;
    logic FETCH_STROBE = 0, OPCODE_ILLEGAL = 0, CORE_BOUNDARY = 0, CORE_TRAP = 0, CORE_INTERRUPT_RETURN_INSTR = 0;
    logic CORE_WFI = 0, CORE_SEI = 0, CORE_CLI = 0, CORE_SP_LOAD = 0, REG_WR = 0, REG_RD = 0;
    logic [15:0] FETCH_ADDR = 0, CORE_PC = 16'h1234;
    logic [7:0] CORE_X = 8'h11, CORE_A = 8'h22, CORE_CC = 8'h00, CORE_SP_DATA = 0, PERIPH_IRQ = 0;
    logic [7:0] REG_ADDR = 0, REG_WDATA = 0, MEM_WDATA, MEM_RDATA, REG_RDATA, CC_VALUE, A_VALUE, X_VALUE, rd;
    logic [15:0] MEM_ADDR, PC_VALUE, SP_VALUE, TIMER_CNT_INIT;
    logic MEM_WR, MEM_RD, CORE_RST, CORE_HOLD, PC_LOAD, CTX_LOAD, I_MASK, WAIT_MODE, OSC_EN, PERIPH_RST;
    logic FAST_CLK_SEL, VSYNC_SEL, FLY_SYN_SEL, HSYNC_DIV_EN;
    int failures = 0, comparisons = 0, cyc = 0, rst_cyc;
    riwc_ctrl #(.OSC_DELAY_CYC(13'h0008)) dut_u (.CLK(CLK), .RSTN(RSTN), .RESET_PIN_N(RESET_PIN_N),
        .EXT_EDGE_IRQ_A(EXT_EDGE_IRQ_A), .EXT_EDGE_IRQ_B(EXT_EDGE_IRQ_B), .FETCH_STROBE(FETCH_STROBE),
        .FETCH_ADDR(FETCH_ADDR), .OPCODE_ILLEGAL(OPCODE_ILLEGAL), .CORE_BOUNDARY(CORE_BOUNDARY),
        .CORE_TRAP(CORE_TRAP), .CORE_INTERRUPT_RETURN_INSTR(CORE_INTERRUPT_RETURN_INSTR), .CORE_WFI(CORE_WFI), .CORE_SEI(CORE_SEI),
        .CORE_CLI(CORE_CLI), .CORE_PC(CORE_PC), .CORE_X(CORE_X), .CORE_A(CORE_A), .CORE_CC(CORE_CC),
        .CORE_SP_LOAD(CORE_SP_LOAD), .CORE_SP_DATA(CORE_SP_DATA), .PERIPH_IRQ(PERIPH_IRQ),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
        .MEM_RDATA(MEM_RDATA), .CORE_RST(CORE_RST), .CORE_HOLD(CORE_HOLD), .PC_LOAD(PC_LOAD),
        .PC_VALUE(PC_VALUE), .CTX_LOAD(CTX_LOAD), .CC_VALUE(CC_VALUE), .A_VALUE(A_VALUE),
        .X_VALUE(X_VALUE), .SP_VALUE(SP_VALUE), .I_MASK(I_MASK), .WAIT_MODE(WAIT_MODE), .OSC_EN(OSC_EN),
        .PERIPH_RST(PERIPH_RST), .TIMER_CNT_INIT(TIMER_CNT_INIT), .FAST_CLK_SEL(FAST_CLK_SEL),
        .VSYNC_SEL(VSYNC_SEL), .FLY_SYN_SEL(FLY_SYN_SEL), .HSYNC_DIV_EN(HSYNC_DIV_EN),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
    riwc_mem_model mdl_u (.CLK(CLK), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR),
        .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA));
    initial forever #5 CLK = ~CLK;
    task print_verdict;
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            print_verdict;
        end
    end
    // register port cycles
    task wr(input [7:0] a, input [7:0] d);
        @(posedge CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
        @(posedge CLK) REG_WR <= 0;
    endtask
    task rdr(input [7:0] a);
        @(posedge CLK) {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge CLK) REG_RD <= 0;
        #1 rd = REG_RDATA;
    endtask
    // instruction boundary with qualifiers t, i, w
    task bnd(input t, input i, input w);
        @(posedge CLK) {CORE_BOUNDARY, CORE_TRAP, CORE_INTERRUPT_RETURN_INSTR, CORE_WFI} <= {1'b1, t, i, w};
        @(posedge CLK) {CORE_BOUNDARY, CORE_TRAP, CORE_INTERRUPT_RETURN_INSTR, CORE_WFI} <= 4'h0;
    endtask
    // wait for a pc load, counting reset cycles
    task wait_load;
        rst_cyc = 0;
        for (int k = 0; k < 80 && PC_LOAD !== 1'b1; k++) begin
            @(posedge CLK) #1;
            if (CORE_RST === 1'b1) rst_cyc++;
        end
    endtask
    task svc(input t, input [15:0] v);
        bnd(t, 0, 0);
        wait_load;
        `CHK("vector", v, PC_VALUE)
    endtask
    task ret;
        bnd(0, 1, 0);
        wait_load;
        `CHK("ctx", 1'b1, CTX_LOAD)
        `CHK("ret pc", CORE_PC, PC_VALUE)
    endtask
    task t_edge;
        @(posedge CLK) CORE_CLI <= 1;
        @(posedge CLK) CORE_CLI <= 0;
        wr(`RIWC_ADDR_MISC, 8'h11);
        @(posedge CLK) EXT_EDGE_IRQ_A <= 0;
        repeat (5) @(posedge CLK);
        rdr(`RIWC_ADDR_MISC);
        `CHK("latch a", 8'h15, rd)
        svc(0, 16'hF2F3);
        `CHK("pcl", 8'h34, mdl_u.stk[8'hFF])
        `CHK("ctx bytes", 32'h12112200, {mdl_u.stk[8'hFE], mdl_u.stk[8'hFD], mdl_u.stk[8'hFC], mdl_u.stk[8'hFB]})
        `CHK("sp push", 16'h01FA, SP_VALUE)
        `CHK("mask in", 1'b1, I_MASK)
        ret;
        `CHK("ret regs", 24'h002211, {CC_VALUE, A_VALUE, X_VALUE})
        `CHK("mask out", 1'b0, I_MASK)
        rdr(`RIWC_ADDR_MISC);
        `CHK("latch kept", 8'h15, rd)
        wr(`RIWC_ADDR_MISC, 8'h11);
        {EXT_EDGE_IRQ_A, EXT_EDGE_IRQ_B} <= 2'b10;
        repeat (5) @(posedge CLK);
        rdr(`RIWC_ADDR_MISC);
        `CHK("latch b", 8'h19, rd)
        bnd(0, 0, 0);
        repeat (2) @(posedge CLK) #1;
        `CHK("disabled held", 1'b0, CORE_HOLD)
        wr(`RIWC_ADDR_MISC, 8'h1A);
        svc(0, 16'hF4F5);
        ret;
        EXT_EDGE_IRQ_B <= 1;
        wr(`RIWC_ADDR_MISC, 8'h10);
    endtask
    task t_prio;
        PERIPH_IRQ <= 8'h81;
        svc(0, 16'hFAFB);
        PERIPH_IRQ <= 8'h80;
        ret;
        svc(0, 16'hE6E7);
        PERIPH_IRQ <= 8'h00;
        ret;
    endtask
    task t_trap;
        @(posedge CLK) {CORE_SEI, PERIPH_IRQ} <= {1'b1, 8'h40};
        @(posedge CLK) CORE_SEI <= 0;
        bnd(0, 0, 0);
        repeat (2) @(posedge CLK) #1;
        `CHK("masked held", 1'b0, CORE_HOLD)
        svc(1, 16'hFCFD);
        ret;
        `CHK("mask restored", 1'b1, I_MASK)
        @(posedge CLK) CORE_CLI <= 1;
        @(posedge CLK) CORE_CLI <= 0;
        svc(0, 16'hEAEB);
        PERIPH_IRQ <= 8'h00;
        ret;
    endtask
    task t_wait;
        @(posedge CLK) CORE_SEI <= 1;
        @(posedge CLK) CORE_SEI <= 0;
        bnd(0, 0, 1);
        #1 `CHK("wait", 3'b101, {WAIT_MODE, I_MASK, CORE_HOLD})
        rdr(`RIWC_ADDR_STAT);
        `CHK("stat", 8'h01, rd)
        rdr(8'h33);
        `CHK("unmapped", 8'h00, rd)
        PERIPH_IRQ <= 8'h40;
        wait_load;
        `CHK("wait exit", 17'h0EAEB, {WAIT_MODE, PC_VALUE})
        PERIPH_IRQ <= 8'h00;
        ret;
    endtask
    task t_illegal;
        for (int i = 0; i < 3; i++) begin
            @(posedge CLK) {FETCH_STROBE, OPCODE_ILLEGAL, FETCH_ADDR} <= {i < 2, i == 2, i ? 16'h0080 : 16'h0100};
            @(posedge CLK) {FETCH_STROBE, OPCODE_ILLEGAL} <= 2'b00;
            repeat (2) @(posedge CLK) #1;
            if (i == 0) `CHK("legal fetch", 1'b0, CORE_RST)
            else begin
                wait_load;
                `CHK("ill reset", 17'h1FEFF, {rst_cyc > 4, PC_VALUE})
            end
        end
    endtask
    task t_pin;
        @(posedge CLK) {CORE_SP_LOAD, CORE_SP_DATA} <= {1'b1, 8'h80};
        @(posedge CLK) CORE_SP_LOAD <= 0;
        #1 `CHK("sp load", 16'h0180, SP_VALUE)
        wr(`RIWC_ADDR_MISC, 8'hE0);
        #1 `CHK("misc out", 4'hE, {VSYNC_SEL, FLY_SYN_SEL, HSYNC_DIV_EN, FAST_CLK_SEL})
        RESET_PIN_N <= 0;
        repeat (100) @(posedge CLK);
        `CHK("osc off", 1'b0, OSC_EN)
        RESET_PIN_N <= 1;
        wait_load;
        `CHK("osc delay", 1'b1, rst_cyc >= 8)
        `CHK("pin reset", 34'h3FBFC07FE, {PC_VALUE, SP_VALUE, I_MASK, WAIT_MODE})
        rdr(`RIWC_ADDR_MISC);
        `CHK("misc reset", `RIWC_MISC_RST, rd)
    endtask
    initial begin
        repeat (2) @(posedge CLK);
        RSTN <= 1;
        wait_load;
        `CHK("first vector", 16'hFEFF, PC_VALUE)
        `CHK("timer init", 16'hFFFC, TIMER_CNT_INIT)
        t_edge;
        t_prio;
        t_trap;
        t_wait;
        t_illegal;
        t_pin;
        print_verdict;
    end
endmodule // riwc_ctrl_tb_top
